//--- ingress_cos_classifier.sv
// Ingress class-of-service classifier: per-port mode, lookup tables, queue choice
`timescale 1ns/1ns
`include "cos_defines.svh"
//
// Contract
// [R1] ToS mode indexes an eight-entry class table with the IP ToS field.
// [R2] A tagged frame goes to the queue in its selected entry; any queue allowed. Code uses the entry for IP frames (frame_is_ip), tagged or not.
// [R3] ToS and DSCP classification are mutually exclusive; enabling one disables other.
// [R4] DSCP table steers queues only while some port is in DSCP mode.
// [R5] Each DSCP entry holds a class 0 to 3, one of four queues.
// [R6] Port mode picks the queue only from the ingress port's priority.
// [R7] Port mode uses only the highest or lowest queue.
// [R8] The elevated port-mode choice maps to queue 3 only.
// [R9] Destination mode looks up the destination MAC and uses the entry's class.
// [R10] Software installs the address statically in forwarding_table before the entry.
// [R11] Software sets egress ports to destination mode alone, no other choice.
// [R12] After reset every port is in 802.1p mode.
// [R13] Per-port mode: none, port map, 802.1p, destination, ToS, DSCP; none clears.
// [R14] DSCP table has 64 entries by six-bit DSCP; all entries reset to 0.
// [R15] No destination-table match falls back to class 0.
module ingress_cos_classifier #(
    parameter int NUM_PORTS = `COS_NUM_PORTS,
    parameter int DEST_ENTRIES = `COS_DEST_ENTRIES,
    localparam int PW = $clog2(NUM_PORTS),
    localparam int TW = $clog2(`COS_TOS_ENTRIES),
    localparam int DW = $clog2(`COS_DSCP_ENTRIES),
    localparam int UW = $clog2(DEST_ENTRIES + 1)
) (
    input wire logic mclk,
    input wire logic rstn,
    // Per-port mode and port-mapping priority
    input wire logic mode_wr,
    input wire logic [PW-1:0] mode_port,
    input wire cos_pkg::prio_mode_t mode_val,
    input wire logic port_prio_wr,
    input wire logic [PW-1:0] port_prio_port,
    input wire logic port_prio_high,
    // ToS/DSCP global selection
    input wire logic ip_sel_wr,
    input wire cos_pkg::ip_sel_t ip_sel_val,
    // Table programming
    input wire logic tos_wr,
    input wire logic [TW-1:0] tos_wr_idx,
    input wire cos_pkg::class_t tos_wr_class,
    input wire logic dscp_wr,
    input wire logic [DW-1:0] dscp_wr_idx,
    input wire cos_pkg::class_t dscp_wr_class,
    input wire logic dest_wr,
    input wire logic dest_del,
    input wire logic [`COS_MAC_W-1:0] dest_wr_mac,
    input wire cos_pkg::class_t dest_wr_class,
    input wire logic forwarding_table_static_hit,
    // Readback
    input wire logic [PW-1:0] mon_port,
    output cos_pkg::prio_mode_t mon_mode,
    output logic mon_port_high,
    input wire logic [TW-1:0] mon_tos_idx,
    output cos_pkg::class_t mon_tos_class,
    input wire logic [DW-1:0] mon_dscp_idx,
    output cos_pkg::class_t mon_dscp_class,
    output cos_pkg::ip_sel_t ip_sel,
    output logic dscp_active,
    output logic dest_refused,
    output logic [UW-1:0] dest_used,
    output logic cfg_refused,
    // Frame path
    input wire logic frame_valid,
    input wire logic [PW-1:0] frame_port,
    input wire logic frame_is_ip,
    input wire logic [7:0] frame_tos,
    input wire logic frame_tagged,
    input wire logic [2:0] frame_pcp,
    input wire logic [`COS_MAC_W-1:0] frame_dmac,
    output logic queue_valid,
    output cos_pkg::class_t queue_class,
    output logic queue_dest_hit
);
    // ----------
    // Elaboration checks
    // ----------
    if (NUM_PORTS < 2) begin : g_bad_ports
        $error("ingress_cos_classifier: NUM_PORTS must be at least 2");
    end
    if (DEST_ENTRIES < 1) begin : g_bad_dest
        $error("ingress_cos_classifier: DEST_ENTRIES must be at least 1");
    end

    // ----------
    // Per-port configuration
    // ----------
    cos_pkg::prio_mode_t mode_r [NUM_PORTS];
    logic [NUM_PORTS-1:0] high_r;
    logic [NUM_PORTS-1:0] is_dscp;
    logic mode_legal;
    logic port_ok;
    logic prio_port_ok;
    logic ip_conflict;

    // Undefined mode codes and out-of-range ports are dropped, not stored
    always_comb begin
        unique case (mode_val)
            cos_pkg::MODE_NONE, cos_pkg::MODE_PORT_MAP, cos_pkg::MODE_DOT1P,
            cos_pkg::MODE_DEST, cos_pkg::MODE_TOS, cos_pkg::MODE_DSCP: mode_legal = 1'b1; // R13
            default: mode_legal = 1'b0;
        endcase
    end

    assign port_ok = 32'(mode_port) < NUM_PORTS;
    assign prio_port_ok = 32'(port_prio_port) < NUM_PORTS;

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                mode_r[p] <= cos_pkg::prio_mode_t'(`COS_MODE_RESET); // R12
            end else if (mode_wr && mode_legal && mode_port == PW'(p)) begin
                mode_r[p] <= mode_val; // R13
            end
        end
        always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                high_r[p] <= 1'b0;
            end else if (port_prio_wr && port_prio_port == PW'(p)) begin
                high_r[p] <= port_prio_high; // R6
            end
        end
        assign is_dscp[p] = mode_r[p] == cos_pkg::MODE_DSCP;
    end

    assign dscp_active = |is_dscp; // R4

    // ----------
    // ToS/DSCP exclusive selection
    // ----------
    cos_pkg::ip_sel_t ip_sel_r;

    // The last enable written wins, so one choice always shuts out the other
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ip_sel_r <= cos_pkg::IP_SEL_OFF;
        end else if (ip_sel_wr) begin
            unique case (ip_sel_val)
                cos_pkg::IP_SEL_TOS: ip_sel_r <= cos_pkg::IP_SEL_TOS; // R3
                cos_pkg::IP_SEL_DSCP: ip_sel_r <= cos_pkg::IP_SEL_DSCP; // R3
                default: ip_sel_r <= cos_pkg::IP_SEL_OFF;
            endcase
        end
    end

    assign ip_sel = ip_sel_r;

    // A port mode naming the shut-out lookup is flagged, though still stored
    assign ip_conflict = mode_wr && mode_legal &&
        ((mode_val == cos_pkg::MODE_TOS && ip_sel_r == cos_pkg::IP_SEL_DSCP) ||
         (mode_val == cos_pkg::MODE_DSCP && ip_sel_r == cos_pkg::IP_SEL_TOS)); // R3

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cfg_refused <= 1'b0;
        end else begin
            cfg_refused <= (mode_wr && (!mode_legal || !port_ok)) ||
                           (port_prio_wr && !prio_port_ok) || ip_conflict;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mon_mode <= cos_pkg::prio_mode_t'(`COS_MODE_RESET);
            mon_port_high <= 1'b0;
        end else begin
            mon_mode <= mode_r[mon_port];
            mon_port_high <= high_r[mon_port];
        end
    end

    // ----------
    // Lookup tables
    // ----------
    cos_pkg::class_t tos_class;
    cos_pkg::class_t dscp_class;
    cos_pkg::class_t dest_class;
    cos_pkg::class_t tos_mon_w;
    cos_pkg::class_t dscp_mon_w;
    logic dest_hit;

    class_table #(
        .ENTRIES(`COS_TOS_ENTRIES)
    ) u_tos_table (
        .mclk(mclk),
        .rstn(rstn),
        .wr_en(tos_wr),
        .wr_idx(tos_wr_idx),
        .wr_class(tos_wr_class),
        .rd_idx(frame_tos[`COS_TOS_MSB:`COS_TOS_LSB]), // R1
        .rd_class(tos_class),
        .mon_idx(mon_tos_idx),
        .mon_class(tos_mon_w)
    );

    class_table #(
        .ENTRIES(`COS_DSCP_ENTRIES)
    ) u_dscp_table (
        .mclk(mclk),
        .rstn(rstn),
        .wr_en(dscp_wr),
        .wr_idx(dscp_wr_idx),
        .wr_class(dscp_wr_class), // R5
        .rd_idx(frame_tos[`COS_DSCP_MSB:`COS_DSCP_LSB]), // R14
        .rd_class(dscp_class),
        .mon_idx(mon_dscp_idx),
        .mon_class(dscp_mon_w)
    );

    dest_prio_table #(
        .ENTRIES(DEST_ENTRIES)
    ) u_dest_table (
        .mclk(mclk),
        .rstn(rstn),
        .wr_en(dest_wr),
        .wr_del(dest_del),
        .wr_mac(dest_wr_mac),
        .wr_class(dest_wr_class),
        .fwd_static_hit(forwarding_table_static_hit),
        .wr_refused(dest_refused),
        .lk_mac(frame_dmac),
        .lk_hit(dest_hit),
        .lk_class(dest_class),
        .used_count(dest_used)
    );

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mon_tos_class <= `COS_CLASS_RESET;
            mon_dscp_class <= `COS_CLASS_RESET;
        end else begin
            mon_tos_class <= tos_mon_w;
            mon_dscp_class <= dscp_mon_w;
        end
    end

    // ----------
    // Queue selection
    // ----------
    cos_pkg::prio_mode_t frame_mode;
    cos_pkg::class_t class_nxt;
    logic hit_nxt;

    assign frame_mode = mode_r[frame_port];

    // Non-IP or wrongly-enabled lookups fall to the lowest queue
    always_comb begin
        class_nxt = `COS_CLASS_LOW;
        hit_nxt = 1'b0;
        unique case (frame_mode)
            cos_pkg::MODE_NONE: class_nxt = `COS_CLASS_LOW; // R13
            cos_pkg::MODE_PORT_MAP: begin
                class_nxt = high_r[frame_port] ? `COS_CLASS_HIGH : `COS_CLASS_LOW; // R7 R8
            end
            cos_pkg::MODE_DOT1P: begin
                if (frame_tagged) begin
                    class_nxt = frame_pcp[`COS_PCP_CLASS_MSB:`COS_PCP_CLASS_LSB];
                end
            end
            cos_pkg::MODE_DEST: begin
                class_nxt = dest_class; // R9 R15
                hit_nxt = dest_hit;
            end
            cos_pkg::MODE_TOS: begin
                if (frame_is_ip && ip_sel_r == cos_pkg::IP_SEL_TOS) begin
                    class_nxt = tos_class; // R1 R2 R3
                end
            end
            cos_pkg::MODE_DSCP: begin
                if (frame_is_ip && ip_sel_r == cos_pkg::IP_SEL_DSCP && dscp_active) begin
                    class_nxt = dscp_class; // R2 R3 R4
                end
            end
            default: class_nxt = `COS_CLASS_LOW;
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            queue_valid <= 1'b0;
        end else begin
            queue_valid <= frame_valid && 32'(frame_port) < NUM_PORTS;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            queue_class <= `COS_CLASS_RESET;
            queue_dest_hit <= 1'b0;
        end else if (frame_valid) begin
            queue_class <= class_nxt;
            queue_dest_hit <= hit_nxt;
        end
    end
endmodule // ingress_cos_classifier

//--- cos_defines.svh
// Constants of the ingress class-of-service classifier
`ifndef COS_DEFINES_SVH
`define COS_DEFINES_SVH

`define COS_NUM_PORTS 28
`define COS_TOS_ENTRIES 8
`define COS_DSCP_ENTRIES 64
`define COS_DEST_ENTRIES 16
`define COS_CLASS_W 2
`define COS_CLASS_RESET 2'h0
`define COS_CLASS_LOW 2'h0
`define COS_CLASS_HIGH 2'h3
`define COS_MODE_RESET 3'h2
`define COS_TOS_MSB 7
`define COS_TOS_LSB 5
`define COS_DSCP_MSB 7
`define COS_DSCP_LSB 2
`define COS_PCP_CLASS_MSB 2
`define COS_PCP_CLASS_LSB 1
`define COS_MAC_W 48

`endif

//--- cos_pkg.sv
// Types shared by the classifier files
package cos_pkg;

    typedef logic [1:0] class_t;

    typedef enum logic [2:0] {
        MODE_NONE     = 3'b000,
        MODE_PORT_MAP = 3'b001,
        MODE_DOT1P    = 3'b010,
        MODE_DEST     = 3'b011,
        MODE_TOS      = 3'b100,
        MODE_DSCP     = 3'b101
    } prio_mode_t;

    typedef enum logic [1:0] {
        IP_SEL_OFF  = 2'b00,
        IP_SEL_TOS  = 2'b01,
        IP_SEL_DSCP = 2'b10
    } ip_sel_t;

endpackage

//--- class_table.sv
// Programmable index-to-class table held in flip-flops
`timescale 1ns/1ns
`include "cos_defines.svh"
module class_table #(
    parameter int ENTRIES = `COS_TOS_ENTRIES,
    localparam int IW = $clog2(ENTRIES)
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic [IW-1:0] wr_idx,
    input wire cos_pkg::class_t wr_class,
    input wire logic [IW-1:0] rd_idx,
    output cos_pkg::class_t rd_class,
    input wire logic [IW-1:0] mon_idx,
    output cos_pkg::class_t mon_class
);
    if (ENTRIES < 2 || (1 << IW) != ENTRIES) begin : g_bad_entries
        $error("class_table: ENTRIES must be a power of two, at least 2");
    end

    cos_pkg::class_t entry_r [ENTRIES];

    for (genvar i = 0; i < ENTRIES; i++) begin : g_entry
        always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                entry_r[i] <= `COS_CLASS_RESET;
            end else if (wr_en && wr_idx == IW'(i)) begin
                entry_r[i] <= wr_class;
            end
        end
    end

    assign rd_class = entry_r[rd_idx];
    assign mon_class = entry_r[mon_idx];
endmodule // class_table

//--- dest_prio_table.sv
// Destination-address priority table with associative lookup
`timescale 1ns/1ns
`include "cos_defines.svh"
module dest_prio_table #(
    parameter int ENTRIES = `COS_DEST_ENTRIES,
    localparam int CW = $clog2(ENTRIES + 1)
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic wr_del,
    input wire logic [`COS_MAC_W-1:0] wr_mac,
    input wire cos_pkg::class_t wr_class,
    input wire logic fwd_static_hit,
    output logic wr_refused,
    input wire logic [`COS_MAC_W-1:0] lk_mac,
    output logic lk_hit,
    output cos_pkg::class_t lk_class,
    output logic [CW-1:0] used_count
);
    if (ENTRIES < 1) begin : g_bad_entries
        $error("dest_prio_table: ENTRIES must be at least 1");
    end

    logic [ENTRIES-1:0] valid_r;
    logic [`COS_MAC_W-1:0] mac_r [ENTRIES];
    cos_pkg::class_t class_r [ENTRIES];
    logic [ENTRIES-1:0] wr_match;
    logic [ENTRIES-1:0] lk_match;
    logic [ENTRIES-1:0] wr_sel;
    logic any_match;
    logic any_free;
    logic refuse;

    // Update hits an existing entry first, otherwise the lowest free slot
    always_comb begin
        wr_sel = '0;
        any_match = |wr_match;
        any_free = 1'b0;
        for (int i = 0; i < ENTRIES; i++) begin
            if (any_match) begin
                wr_sel[i] = wr_match[i];
            end else if (!valid_r[i] && !any_free) begin
                wr_sel[i] = 1'b1;
                any_free = 1'b1;
            end
        end
    end

    // Creation needs the address already static in the forwarding table
    assign refuse = wr_en && !wr_del && (!fwd_static_hit || (!any_match && !any_free)); // R10

    for (genvar i = 0; i < ENTRIES; i++) begin : g_entry
        assign wr_match[i] = valid_r[i] && mac_r[i] == wr_mac;
        assign lk_match[i] = valid_r[i] && mac_r[i] == lk_mac;
        always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
                valid_r[i] <= 1'b0;
                mac_r[i] <= '0;
                class_r[i] <= `COS_CLASS_RESET;
            end else if (wr_en && wr_del && wr_match[i]) begin
                valid_r[i] <= 1'b0;
            end else if (wr_en && !wr_del && !refuse && wr_sel[i]) begin
                valid_r[i] <= 1'b1;
                mac_r[i] <= wr_mac;
                class_r[i] <= wr_class;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wr_refused <= 1'b0;
        end else begin
            wr_refused <= refuse;
        end
    end

    always_comb begin
        lk_hit = 1'b0;
        lk_class = `COS_CLASS_RESET; // R15
        used_count = '0;
        for (int i = 0; i < ENTRIES; i++) begin
            used_count = used_count + CW'(valid_r[i]);
            if (lk_match[i] && !lk_hit) begin
                lk_hit = 1'b1;
                lk_class = class_r[i]; // R9
            end
        end
    end
endmodule // dest_prio_table

//--- fwd_table_model.sv
// Forwarding-table partner: static unicast entries answered by address
`timescale 1ns/1ns
module fwd_table_model #(
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic add,
    input wire logic [47:0] add_mac,
    input wire logic [47:0] look_mac,
    output logic hit
);
    logic [47:0] mac_r [DEPTH];
    logic [DEPTH-1:0] used_r;
    int fill_r;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            used_r <= '0;
            fill_r <= 0;
        end else if (add && fill_r < DEPTH) begin
            mac_r[fill_r] <= add_mac;
            used_r[fill_r] <= 1'b1;
            fill_r <= fill_r + 1;
        end
    end
    // Only installed static addresses answer
    always_comb begin
        hit = 1'b0;
        for (int i = 0; i < DEPTH; i++) begin
            if (used_r[i] && mac_r[i] == look_mac) begin
                hit = 1'b1;
            end
        end
    end
endmodule // fwd_table_model

//--- ingress_cos_classifier_chk.sv
// Port-level assertions for the ingress class-of-service classifier
`timescale 1ns/1ns
module ingress_cos_classifier_chk #(
    parameter int NUM_PORTS = 28,
    parameter int DEST_ENTRIES = 16,
    localparam int PW = $clog2(NUM_PORTS),
    localparam int UW = $clog2(DEST_ENTRIES + 1)
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic mode_wr,
    input wire logic [PW-1:0] mode_port,
    input wire cos_pkg::prio_mode_t mode_val,
    input wire logic port_prio_wr,
    input wire logic ip_sel_wr,
    input wire cos_pkg::ip_sel_t ip_sel_val,
    input wire logic dest_wr,
    input wire logic dest_del,
    input wire logic forwarding_table_static_hit,
    input wire logic [PW-1:0] mon_port,
    input wire cos_pkg::prio_mode_t mon_mode,
    input wire cos_pkg::ip_sel_t ip_sel,
    input wire logic dscp_active,
    input wire logic dest_refused,
    input wire logic [UW-1:0] dest_used,
    input wire logic cfg_refused,
    input wire logic frame_valid,
    input wire logic [PW-1:0] frame_port,
    input wire logic frame_is_ip,
    input wire logic frame_tagged,
    input wire logic queue_valid,
    input wire cos_pkg::class_t queue_class,
    input wire logic queue_dest_hit
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    frame_answer_a: assert property (
        frame_valid && frame_port < NUM_PORTS |=> queue_valid) else $error("no queue answer");
    class_hold_a: assert property (
        !frame_valid |=> !queue_valid && $stable(queue_class) && $stable(queue_dest_hit))
        else $error("queue moved idle");
    port_ends_a: assert property (
        frame_valid && !frame_is_ip && !frame_tagged
        |=> queue_dest_hit || queue_class inside {2'h0, 2'h3})
        else $error("middle queue untagged");
    ip_sel_a: assert property (
        ip_sel_wr && ip_sel_val != 2'h3 |=> ip_sel == $past(ip_sel_val))
        else $error("ip_sel not taken");
    ip_hold_a: assert property (!ip_sel_wr |=> $stable(ip_sel))
        else $error("ip_sel moved");
    dscp_on_a: assert property (
        mode_wr && mode_val == cos_pkg::MODE_DSCP && mode_port < NUM_PORTS |=> dscp_active)
        else $error("dscp not active");
    bad_mode_a: assert property (mode_wr && 3'(mode_val) >= 3'h6 |=> cfg_refused)
        else $error("bad mode taken");
    cfg_quiet_a: assert property (!mode_wr && !port_prio_wr |=> !cfg_refused)
        else $error("idle refusal");
    dest_ref_a: assert property (
        dest_wr && !dest_del && !forwarding_table_static_hit
        |=> dest_refused && $stable(dest_used)) else $error("unstatic entry accepted");
    mon_mode_a: assert property (
        mode_wr && 3'(mode_val) < 3'h6 && mode_port < NUM_PORTS && mon_port == mode_port
        ##1 ($stable(mon_port) && !mode_wr) |=> mon_mode == $past(mode_val, 2))
        else $error("mode differs");
    cover property (queue_valid && queue_dest_hit);
    cover property (cfg_refused);
    cover property (dest_refused);
    cover property (dscp_active && queue_valid);
endmodule // ingress_cos_classifier_chk
bind ingress_cos_classifier ingress_cos_classifier_chk #(
    .NUM_PORTS(NUM_PORTS), .DEST_ENTRIES(DEST_ENTRIES)) u_chk (
    .mclk, .rstn, .mode_wr, .mode_port, .mode_val, .port_prio_wr, .ip_sel_wr, .ip_sel_val,
    .dest_wr, .dest_del, .forwarding_table_static_hit, .mon_port, .mon_mode, .ip_sel,
    .dscp_active, .dest_refused, .dest_used, .cfg_refused, .frame_valid, .frame_port,
    .frame_is_ip, .frame_tagged, .queue_valid, .queue_class, .queue_dest_hit);

//--- ingress_cos_classifier_tb_top.sv
// Self-checking bench for the ingress class-of-service classifier
`timescale 1ns/1ns
module ingress_cos_classifier_tb_top;
    localparam int NP = 28;
    localparam int DE = 4;
    localparam logic [47:0] MA = 48'h0200_0000_0A00;
    localparam logic [47:0] MB = 48'h0200_0000_0B00;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [5:0] stb = '0;
    logic [4:0] mode_port = '0, pp_port = '0, mon_port = '0, frame_port = '0;
    cos_pkg::prio_mode_t mode_val = cos_pkg::MODE_NONE;
    cos_pkg::ip_sel_t ip_sel_val = cos_pkg::IP_SEL_OFF;
    cos_pkg::class_t wcls = '0;
    logic pp_high = 1'b0, dest_del = 1'b0, frame_valid = 1'b0, frame_is_ip = 1'b0;
    logic frame_tagged = 1'b0, fwd_add = 1'b0, static_hit;
    logic [2:0] tidx = '0, mon_tidx = '0, frame_pcp = '0, dest_used;
    logic [5:0] didx = '0, mon_didx = '0;
    logic [7:0] frame_tos = '0;
    logic [47:0] dmac = '0, frame_dmac = '0;
    cos_pkg::prio_mode_t mon_mode;
    cos_pkg::class_t mon_tcls, mon_dcls, queue_class;
    cos_pkg::ip_sel_t ip_sel;
    logic mon_high, dscp_active, dest_refused, cfg_refused, queue_valid, queue_dest_hit;
    int bad_count = 0, n_checks = 0, cyc = 0;
    fwd_table_model u_fwd_table_model (.mclk(mclk), .rstn(rstn), .add(fwd_add),
        .add_mac(dmac), .look_mac(dmac), .hit(static_hit));
    ingress_cos_classifier #(.NUM_PORTS(NP), .DEST_ENTRIES(DE)) u_ingress_cos_classifier (
        .mclk, .rstn, .mode_wr(stb[0]), .mode_port, .mode_val, .port_prio_wr(stb[1]),
        .port_prio_port(pp_port), .port_prio_high(pp_high), .ip_sel_wr(stb[2]), .ip_sel_val,
        .tos_wr(stb[3]), .tos_wr_idx(tidx), .tos_wr_class(wcls), .dscp_wr(stb[4]),
        .dscp_wr_idx(didx), .dscp_wr_class(wcls), .dest_wr(stb[5]), .dest_del,
        .dest_wr_mac(dmac), .dest_wr_class(wcls), .forwarding_table_static_hit(static_hit),
        .mon_port, .mon_mode, .mon_port_high(mon_high), .mon_tos_idx(mon_tidx),
        .mon_tos_class(mon_tcls), .mon_dscp_idx(mon_didx), .mon_dscp_class(mon_dcls),
        .ip_sel, .dscp_active, .dest_refused, .dest_used, .cfg_refused, .frame_valid,
        .frame_port, .frame_is_ip, .frame_tos, .frame_tagged, .frame_pcp, .frame_dmac,
        .queue_valid, .queue_class, .queue_dest_hit);
    always #50 mclk = ~mclk;
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Ceiling far above the run's length
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // Strobes last one cycle, so calls never collide
    task automatic fin();
        @(posedge mclk);
        stb <= '0;
        fwd_add <= 1'b0;
        frame_valid <= 1'b0;
        #1;
    endtask
    task automatic set_mode(logic [4:0] p, cos_pkg::prio_mode_t m);
        @(posedge mclk);
        mode_port <= p;
        mode_val <= m;
        stb[0] <= 1'b1;
        fin();
    endtask
    // k: 1 port priority, 2 ip selection, 3 tos entry, 4 dscp entry
    task automatic wr(int k, logic [5:0] i, cos_pkg::class_t c);
        @(posedge mclk);
        tidx <= i[2:0];
        didx <= i;
        pp_port <= i[4:0];
        pp_high <= c[0];
        wcls <= c;
        ip_sel_val <= cos_pkg::ip_sel_t'(c);
        stb[k] <= 1'b1;
        fin();
    endtask
    task automatic wr_dest(logic [47:0] m, cos_pkg::class_t c, logic fw = 1'b0, logic del = 1'b0);
        @(posedge mclk);
        dmac <= m;
        wcls <= c;
        dest_del <= del;
        fwd_add <= fw;
        stb[5] <= !fw;
        fin();
    endtask
    task automatic mon(logic [4:0] p, logic [5:0] i);
        @(posedge mclk);
        mon_port <= p;
        mon_tidx <= i[2:0];
        mon_didx <= i;
        fin();
    endtask
    // Odd ToS bytes mark a frame untagged
    task automatic fr(logic [4:0] p, logic ip, logic [7:0] tos, logic [2:0] pcp,
                      logic [1:0] c, logic h = 1'b0, logic [47:0] m = MB);
        @(posedge mclk);
        frame_port <= p;
        frame_is_ip <= ip;
        frame_tos <= tos;
        frame_tagged <= !tos[0];
        frame_pcp <= pcp;
        frame_dmac <= m;
        frame_valid <= 1'b1;
        fin();
        chk("valid", queue_valid, 8'h01);
        chk("class", queue_class, c);
        chk("hit", queue_dest_hit, h);
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            mon(5'(i * 3), 6'(i * 9));
            chk("mode", mon_mode, cos_pkg::MODE_DOT1P);
            chk("tos entry", mon_tcls, 8'h00);
            chk("dscp entry", mon_dcls, 8'h00);
        end
        chk("ip_sel", ip_sel, 8'h00);
        fr(0, 1'b0, 8'h00, 3'h7, 2'h3);
        fr(0, 1'b0, 8'h01, 3'h6, 2'h0);
        $display("test reset done");
        wr(2, 0, 2'h1);
        chk("ip_sel", ip_sel, 8'h01);
        set_mode(1, cos_pkg::MODE_TOS);
        chk("cfg_refused", cfg_refused, 8'h00);
        for (int i = 0; i < 8; i++) wr(3, 6'(i), 2'(7 - i));
        for (int i = 0; i < 8; i++) fr(1, 1'b1, {3'(i), 5'h1F}, 3'h0, 2'(7 - i));
        fr(1, 1'b0, 8'hE0, 3'h7, 2'h0);
        mon(1, 5);
        chk("tos read", mon_tcls, 8'h02);
        chk("mode read", mon_mode, cos_pkg::MODE_TOS);
        $display("test tos done");
        wr(2, 0, 2'h2);
        chk("dscp idle", dscp_active, 8'h00);
        set_mode(1, cos_pkg::MODE_TOS);
        chk("conflict", cfg_refused, 8'h01);
        fr(1, 1'b1, 8'hFF, 3'h0, 2'h0);
        wr(4, 63, 2'h3);
        wr(4, 0, 2'h2);
        wr(4, 33, 2'h1);
        set_mode(2, cos_pkg::MODE_DSCP);
        chk("dscp active", dscp_active, 8'h01);
        fr(2, 1'b1, 8'hFF, 3'h0, 2'h3);
        fr(2, 1'b1, 8'h03, 3'h0, 2'h2);
        fr(2, 1'b1, 8'h86, 3'h0, 2'h1);
        fr(2, 1'b1, 8'h04, 3'h6, 2'h0);
        set_mode(2, cos_pkg::MODE_NONE);
        chk("dscp idle", dscp_active, 8'h00);
        fr(2, 1'b1, 8'hFF, 3'h7, 2'h0);
        $display("test dscp done");
        set_mode(3, cos_pkg::MODE_PORT_MAP);
        wr(1, 3, 2'h1);
        fr(3, 1'b1, 8'h00, 3'h0, 2'h3);
        fr(4, 1'b0, 8'h00, 3'h2, 2'h1);
        wr(1, 3, 2'h0);
        fr(3, 1'b1, 8'hFF, 3'h7, 2'h0);
        wr(1, 30, 2'h1);
        chk("port range", cfg_refused, 8'h01);
        $display("test port done");
        set_mode(5, cos_pkg::MODE_DEST);
        wr_dest(MA, 2'h2);
        chk("no static", dest_refused, 8'h01);
        chk("used", dest_used, 8'h00);
        wr_dest(MA, 2'h0, 1'b1);
        wr_dest(MA, 2'h2);
        chk("static ok", dest_refused, 8'h00);
        fr(5, 1'b1, 8'hFF, 3'h7, 2'h2, 1'b1, MA);
        fr(5, 1'b1, 8'hFF, 3'h7, 2'h0);
        for (int i = 1; i < DE; i++) begin
            wr_dest(MA + 48'(i), 2'h0, 1'b1);
            wr_dest(MA + 48'(i), 2'h3);
        end
        wr_dest(MB, 2'h0, 1'b1);
        wr_dest(MB, 2'h1);
        chk("full", dest_refused, 8'h01);
        chk("used", dest_used, 8'(DE));
        wr_dest(MA, 2'h1);
        fr(5, 1'b0, 8'h00, 3'h0, 2'h1, 1'b1, MA);
        wr_dest(MA, 2'h0, 1'b0, 1'b1);
        chk("used", dest_used, 8'(DE - 1));
        fr(5, 1'b1, 8'hFF, 3'h7, 2'h0, 1'b0, MA);
        $display("test dest done");
        set_mode(0, cos_pkg::prio_mode_t'(3'h6));
        chk("bad mode", cfg_refused, 8'h01);
        set_mode(28, cos_pkg::MODE_DSCP);
        chk("bad port", cfg_refused, 8'h01);
        chk("dscp idle", dscp_active, 8'h00);
        mon(0, 0);
        chk("mode kept", mon_mode, cos_pkg::MODE_DOT1P);
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        mon(5, 63);
        chk("mode", mon_mode, cos_pkg::MODE_DOT1P);
        chk("dscp entry", mon_dcls, 8'h00);
        chk("used", dest_used, 8'h00);
        $display("test rerun done");
        conclude();
    end
endmodule // ingress_cos_classifier_tb_top
